// *** logic/smp_pkg.sv ***
// Constants and types shared by the serial memory programming-mode block.
// Assumes a 25 MHz system clock and an external memory array on a simple port.
package smp_pkg;

  // ==========================================================================
  // Timing
  localparam int SYS_CLK_MHZ  = 25;
  localparam int T_PROG_US    = 2500;
  localparam int T_ERASE_US   = 2000;
  // Least times, so whole cycles are exact or rounded up
  localparam int PROG_CYCLES  = T_PROG_US * SYS_CLK_MHZ;
  localparam int ERASE_CYCLES = T_ERASE_US * SYS_CLK_MHZ;

  // ==========================================================================
  // Link and session codes
  localparam logic [6:0] SLAVE_ADDR  = 7'h50;
  localparam logic [7:0] MODE_CODE   = 8'h00;
  localparam logic [7:0] CMD_BLK_PROG   = 8'h01;
  localparam logic [7:0] CMD_BYTE_PROG  = 8'h02;
  localparam logic [7:0] CMD_BLK_CLR    = 8'h03;
  localparam logic [7:0] CMD_BYTE_CLR   = 8'h04;
  localparam logic [7:0] CMD_ADDR_FETCH = 8'h05;
  localparam logic [7:0] CMD_FULL_CLR   = 8'h09;
  localparam logic [7:0] CMD_BLK_NOCLR  = 8'h0B;
  localparam logic [7:0] CMD_PAGE_SEL   = 8'h0C;
  localparam logic [7:0] CMD_CUR_FETCH  = 8'h0D;
  localparam logic [7:0] CMD_BLK_ADV    = 8'h0F;
  localparam logic [7:0] CMD_QUERY      = 8'h13;

  // ==========================================================================
  // Memory layout
  localparam int         PAGE_MSB     = 15;
  localparam int         PAGE_LSB     = 8;
  localparam int         BLOCK_MSB    = 7;
  localparam int         BLOCK_LSB    = 5;
  localparam int         OFFSET_MSB   = 4;
  localparam logic [5:0] BLOCK_BYTES  = 6'h20;
  localparam logic [15:0] PTR_RESET   = 16'h3060;
  localparam logic [15:0] LOCK_ADDR   = 16'h3060;
  localparam logic [15:0] LAST_ADDR   = 16'h1FFF;

  // ==========================================================================
  // Status byte fields
  localparam int ST_LOCKED  = 0;
  localparam int ST_BAD_CMD = 1;
  localparam int ST_ECC_FIX = 2;

  typedef enum logic [2:0] {
    MEM_NONE, MEM_CLR_BYTE, MEM_CLR_BLOCK, MEM_CLR_ALL, MEM_PROG, MEM_READ
  } smp_mem_op_e;

  typedef struct packed {
    smp_mem_op_e  op;
    logic [15:0]  addr;
    logic [11:0]  wdata;
  } smp_mem_cmd_s;

endpackage

// *** logic/smp_prog_mode.sv ***
// Programming-mode command interpreter: serial slave, pointers, memory sequencer.
// Assumes an open-drain bus resolved outside and a memory array that answers
// a read with the stored code word on mem_rdata_in one cycle later.
//
// Functional notes
// - Location is page, block, offset fields
// - Pages of 256, blocks of 32 bytes
// - Block programming lasts about 2.5 ms
// - Select pin sampled at reset release
// - Oscillator, memory on; serial slave awaits
// - Acknowledge address 1010000 write direction
// - Mode code 00000000, then command runs
// - Block program erases then writes 32
// - Byte program: offset, data, erase, write
// - Block clear uses top three bits
// - Byte clear at offset in page
// - Addressed fetch returns byte, pointer increments
// - Full clear erases whole memory
// - Block program without erase, 32 bytes
// - Page select loads page pointer
// - Current fetch returns byte, pointer increments
// - Block advance modulo 8, page carries
// - Condition query returns status byte
// - Stored bytes carry 4 correcting check bits
// - Lock prevents external read of memory
// - Hold clock low while programming runs
// - Pointer starts at page 48 block 3
// - Full clear unlocks, clock held low
`timescale 1ns/10ps
`default_nettype none
module smp_prog_mode #(
  parameter int unsigned PROG_CYCLES  = smp_pkg::PROG_CYCLES,
  parameter int unsigned ERASE_CYCLES = smp_pkg::ERASE_CYCLES
) (
  input  wire logic                  sys_clk_in,
  input  wire logic                  reset_in,
  input  wire logic                  program_select_pin_in,
  input  wire logic                  scl_in,
  input  wire logic                  sda_in,
  input  wire logic [11:0]           mem_rdata_in,
  output logic                       prog_mode_out,
  output logic                       osc_en_out,
  output logic                       mem_power_out,
  output logic                       scl_out,
  output logic                       scl_oe_out,
  output logic                       sda_out,
  output logic                       sda_oe_out,
  output smp_pkg::smp_mem_cmd_s      mem_cmd_out
);

  typedef enum logic [2:0] {L_IDLE, L_ADDR, L_RX, L_ACK, L_TX, L_IGNORE} smp_link_e;
  typedef enum logic [1:0] {AK_WRITE, AK_READ, AK_DATA} smp_ack_e;
  typedef enum logic [2:0] {S_CODE, S_CMD, S_ARG1, S_ARG2, S_DATA} smp_sess_e;
  typedef enum logic [2:0] {M_IDLE, M_ERASE, M_WRITE, M_WAIT, M_READ, M_SAMPLE} smp_mseq_e;

  // ==========================================================================
  // Check bits and pointer arithmetic
  localparam logic [3:0] ECC_COL [8] = '{4'h3, 4'h5, 4'h6, 4'h7, 4'h9, 4'hA, 4'hB, 4'hC};

  function automatic logic [3:0] ecc_bits(input logic [7:0] d);
    logic [3:0] c;
    c = 4'h0;
    for (int i = 0; i < 8; i++) begin
      if (d[i]) c = c ^ ECC_COL[i];
    end
    return c;
  endfunction

  // Returns {fixed, data}; a single flipped check bit leaves the data alone
  function automatic logic [8:0] ecc_correct(input logic [11:0] w);
    logic [3:0] s;
    logic [7:0] d;
    logic       f;
    s = w[11:8] ^ ecc_bits(w[7:0]);
    d = w[7:0];
    f = (s != 4'h0);
    for (int i = 0; i < 8; i++) begin
      if (s == ECC_COL[i]) d[i] = ~d[i];
    end
    return {f, d};
  endfunction

  function automatic logic [15:0] ptr_inc(input logic [15:0] p);
    return (p == smp_pkg::LAST_ADDR) ? 16'h0000 : 16'(p + 16'h0001);
  endfunction

  // ==========================================================================
  // Pin synchronisers; first stages feed only second stages
  logic sel_s1, sel_s2, scl_s1, scl_s2, scl_s3, sda_s1, sda_s2, sda_s3;

  always_ff @(posedge sys_clk_in) begin
    sel_s1 <= program_select_pin_in;
    sel_s2 <= sel_s1;
    scl_s1 <= scl_in;
    scl_s2 <= scl_s1;
    scl_s3 <= scl_s2;
    sda_s1 <= sda_in;
    sda_s2 <= sda_s1;
    sda_s3 <= sda_s2;
  end

  wire logic scl_rise = scl_s2 & ~scl_s3;
  wire logic scl_fall = ~scl_s2 & scl_s3;
  wire logic bus_start = scl_s2 & scl_s3 & sda_s3 & ~sda_s2;
  wire logic bus_stop  = scl_s2 & scl_s3 & ~sda_s3 & sda_s2;

  // ==========================================================================
  // State
  logic                  entry_done_reg, entry_done_next;
  logic                  prog_mode_reg, prog_mode_next;
  smp_link_e             link_reg, link_next;
  smp_ack_e              ack_reg, ack_next;
  smp_sess_e             sess_reg, sess_next;
  smp_mseq_e             mseq_reg, mseq_next;
  logic [2:0]            bit_cnt_reg, bit_cnt_next;
  logic [7:0]            shift_reg, shift_next;
  logic [7:0]            cmd_reg, cmd_next;
  logic [7:0]            arg_reg, arg_next;
  logic [7:0]            tx_reg, tx_next;
  logic [5:0]            cnt_reg, cnt_next;
  logic [5:0]            wlen_reg, wlen_next;
  logic [15:0]           wbase_reg, wbase_next;
  logic [15:0]           ptr_reg, ptr_next;
  logic [16:0]           timer_reg, timer_next;
  logic                  prog_after_reg, prog_after_next;
  logic                  lock_reg, lock_next;
  logic                  bad_cmd_reg, bad_cmd_next;
  logic                  ecc_fix_reg, ecc_fix_next;
  logic                  sda_oe_reg, sda_oe_next;
  logic                  scl_oe_reg, scl_oe_next;
  logic [7:0]            buf_reg [32];
  logic [7:0]            buf_next [32];
  smp_pkg::smp_mem_cmd_s mem_cmd_reg, mem_cmd_next;
  logic                  fire;

  // ==========================================================================
  // Next-state logic
  always_comb begin
    logic [7:0]  b;
    logic [15:0] pg;
    logic [8:0]  rd;
    logic [15:0] wa;
    logic [7:0]  wd;
    b = {shift_reg[6:0], sda_s2};
    pg = {ptr_reg[smp_pkg::PAGE_MSB:smp_pkg::PAGE_LSB], 8'h00};
    rd = ecc_correct(mem_rdata_in);
    wa = 16'(wbase_reg + 16'(cnt_reg));
    wd = buf_reg[cnt_reg[4:0]];
    fire = 1'b0;
    entry_done_next = 1'b1;
    prog_mode_next = entry_done_reg ? prog_mode_reg : sel_s2;
    link_next = link_reg;
    ack_next = ack_reg;
    sess_next = sess_reg;
    mseq_next = mseq_reg;
    bit_cnt_next = bit_cnt_reg;
    shift_next = shift_reg;
    cmd_next = cmd_reg;
    arg_next = arg_reg;
    tx_next = tx_reg;
    cnt_next = cnt_reg;
    wlen_next = wlen_reg;
    wbase_next = wbase_reg;
    ptr_next = ptr_reg;
    timer_next = timer_reg;
    prog_after_next = prog_after_reg;
    lock_next = lock_reg;
    bad_cmd_next = bad_cmd_reg;
    ecc_fix_next = ecc_fix_reg;
    sda_oe_next = sda_oe_reg;
    scl_oe_next = scl_oe_reg;
    buf_next = buf_reg;
    mem_cmd_next = '{smp_pkg::MEM_NONE, mem_cmd_reg.addr, mem_cmd_reg.wdata};

    // Serial slave; idle unless the select strap was caught high
    if (!prog_mode_reg) begin
      link_next = L_IDLE;
    end else if (bus_start) begin
      link_next = L_ADDR;
      bit_cnt_next = 3'h0;
      sda_oe_next = 1'b0;
    end else if (bus_stop) begin
      link_next = L_IDLE;
      sda_oe_next = 1'b0;
    end else begin
      unique case (link_reg)
        L_IDLE, L_IGNORE: begin
        end
        L_ADDR, L_RX: begin
          if (scl_rise) begin
            shift_next = b;
            bit_cnt_next = 3'(bit_cnt_reg + 3'h1);
            if (bit_cnt_reg == 3'h7) begin
              if (link_reg == L_RX) begin
                ack_next = AK_DATA;
                link_next = L_ACK;
              end else if (b[7:1] == smp_pkg::SLAVE_ADDR) begin
                ack_next = b[0] ? AK_READ : AK_WRITE;
                link_next = L_ACK;
              end else begin
                link_next = L_IGNORE;
              end
            end
          end
        end
        L_ACK: begin
          if (scl_fall) begin
            bit_cnt_next = 3'h0;
            if (!sda_oe_reg) begin
              sda_oe_next = 1'b1;
            end else if (ack_reg == AK_READ) begin
              link_next = L_TX;
              shift_next = tx_reg;
              sda_oe_next = ~tx_reg[7];
            end else begin
              link_next = L_RX;
              sda_oe_next = 1'b0;
              fire = (ack_reg == AK_DATA);
            end
          end
        end
        L_TX: begin
          if (scl_fall) begin
            bit_cnt_next = 3'(bit_cnt_reg + 3'h1);
            shift_next = {shift_reg[6:0], 1'b0};
            sda_oe_next = ~shift_reg[6];
            if (bit_cnt_reg == 3'h7) begin
              sda_oe_next = 1'b0;
              link_next = L_IGNORE;
            end
          end
        end
        default: link_next = L_IDLE;
      endcase
    end

    // Command interpreter, run once per acknowledged data byte
    if (fire) begin
      unique case (sess_reg)
        S_CODE: if (shift_reg == smp_pkg::MODE_CODE) sess_next = S_CMD;
        S_CMD: begin
          cmd_next = shift_reg;
          cnt_next = 6'h00;
          case (shift_reg)
            smp_pkg::CMD_BLK_PROG, smp_pkg::CMD_BLK_NOCLR: sess_next = S_DATA;
            smp_pkg::CMD_BYTE_PROG, smp_pkg::CMD_BLK_CLR, smp_pkg::CMD_BYTE_CLR,
            smp_pkg::CMD_ADDR_FETCH, smp_pkg::CMD_PAGE_SEL: sess_next = S_ARG1;
            smp_pkg::CMD_FULL_CLR: begin
              mem_cmd_next.op = smp_pkg::MEM_CLR_ALL;
              lock_next = 1'b0;
              mseq_next = M_ERASE;
              prog_after_next = 1'b0;
            end
            smp_pkg::CMD_CUR_FETCH: begin
              mem_cmd_next = '{smp_pkg::MEM_READ, ptr_reg, mem_cmd_reg.wdata};
              mseq_next = M_READ;
              ptr_next = ptr_inc(ptr_reg);
            end
            smp_pkg::CMD_BLK_ADV: begin
              ptr_next[smp_pkg::BLOCK_MSB:smp_pkg::BLOCK_LSB] =
                3'(ptr_reg[smp_pkg::BLOCK_MSB:smp_pkg::BLOCK_LSB] + 3'h1);
              if (ptr_reg[smp_pkg::BLOCK_MSB:smp_pkg::BLOCK_LSB] == 3'h7) begin
                ptr_next[smp_pkg::PAGE_MSB:smp_pkg::PAGE_LSB] =
                  8'(ptr_reg[smp_pkg::PAGE_MSB:smp_pkg::PAGE_LSB] + 8'h01);
              end
            end
            smp_pkg::CMD_QUERY: begin
              tx_next = 8'h00;
              tx_next[smp_pkg::ST_LOCKED] = lock_reg;
              tx_next[smp_pkg::ST_BAD_CMD] = bad_cmd_reg;
              tx_next[smp_pkg::ST_ECC_FIX] = ecc_fix_reg;
              bad_cmd_next = 1'b0;
              ecc_fix_next = 1'b0;
            end
            default: bad_cmd_next = 1'b1;
          endcase
        end
        S_ARG1: begin
          sess_next = S_CMD;
          case (cmd_reg)
            smp_pkg::CMD_BYTE_PROG: begin
              arg_next = shift_reg;
              sess_next = S_ARG2;
            end
            smp_pkg::CMD_BLK_CLR: begin
              mem_cmd_next.op = smp_pkg::MEM_CLR_BLOCK;
              mem_cmd_next.addr = pg | {8'h00, shift_reg[7:5], 5'h00};
              mseq_next = M_ERASE;
              prog_after_next = 1'b0;
            end
            smp_pkg::CMD_BYTE_CLR: begin
              mem_cmd_next.op = smp_pkg::MEM_CLR_BYTE;
              mem_cmd_next.addr = pg | {8'h00, shift_reg};
              mseq_next = M_ERASE;
              prog_after_next = 1'b0;
            end
            smp_pkg::CMD_ADDR_FETCH: begin
              mem_cmd_next = '{smp_pkg::MEM_READ, pg | {8'h00, shift_reg},
                               mem_cmd_reg.wdata};
              mseq_next = M_READ;
              ptr_next = ptr_inc(pg | {8'h00, shift_reg});
            end
            default: ptr_next[smp_pkg::PAGE_MSB:smp_pkg::PAGE_LSB] = shift_reg;
          endcase
        end
        S_ARG2: begin
          buf_next[0] = shift_reg;
          mem_cmd_next.op = smp_pkg::MEM_CLR_BYTE;
          mem_cmd_next.addr = pg | {8'h00, arg_reg};
          wbase_next = pg | {8'h00, arg_reg};
          wlen_next = 6'h01;
          mseq_next = M_ERASE;
          prog_after_next = 1'b1;
          sess_next = S_CMD;
        end
        S_DATA: begin
          buf_next[cnt_reg[4:0]] = shift_reg;
          cnt_next = 6'(cnt_reg + 6'h01);
          if (cnt_reg == 6'(smp_pkg::BLOCK_BYTES - 6'h01)) begin
            sess_next = S_CMD;
            wbase_next = {ptr_reg[15:smp_pkg::BLOCK_LSB], 5'h00};
            wlen_next = smp_pkg::BLOCK_BYTES;
            if (cmd_reg == smp_pkg::CMD_BLK_PROG) begin
              mem_cmd_next.op = smp_pkg::MEM_CLR_BLOCK;
              mem_cmd_next.addr = {ptr_reg[15:smp_pkg::BLOCK_LSB], 5'h00};
              mseq_next = M_ERASE;
              prog_after_next = 1'b1;
            end else begin
              mseq_next = M_WRITE;
            end
          end
        end
        default: sess_next = S_CMD;
      endcase
      cnt_next = (mseq_next == M_WRITE || mseq_next == M_ERASE) ? 6'h00 : cnt_next;
      timer_next = 17'(ERASE_CYCLES - 1);
      // Clock stays low until the array settles, so no byte can overrun
      if (mseq_next == M_ERASE || mseq_next == M_WRITE) scl_oe_next = 1'b1;
    end

    // Memory sequencer
    unique case (mseq_reg)
      M_IDLE: begin
      end
      M_ERASE: begin
        timer_next = 17'(timer_reg - 17'h1);
        if (timer_reg == 17'h0) begin
          mseq_next = prog_after_reg ? M_WRITE : M_IDLE;
          scl_oe_next = prog_after_reg;
        end
      end
      M_WRITE: begin
        mem_cmd_next = '{smp_pkg::MEM_PROG, wa, {ecc_bits(wd), wd}};
        if (wa == smp_pkg::LOCK_ADDR && wd != 8'h00) lock_next = 1'b1;
        cnt_next = 6'(cnt_reg + 6'h01);
        if (cnt_reg == 6'(wlen_reg - 6'h01)) begin
          mseq_next = M_WAIT;
          timer_next = 17'(PROG_CYCLES - 1);
        end
      end
      M_WAIT: begin
        timer_next = 17'(timer_reg - 17'h1);
        if (timer_reg == 17'h0) begin
          mseq_next = M_IDLE;
          scl_oe_next = 1'b0;
        end
      end
      M_READ: begin
        // Array answers one cycle after the address pulse
        mseq_next = M_SAMPLE;
      end
      M_SAMPLE: begin
        // Set wins over a status query in the same cycle
        if (rd[8]) ecc_fix_next = 1'b1;
        // Locked parts answer zero instead of the stored code
        tx_next = lock_reg ? 8'h00 : rd[7:0];
        mseq_next = M_IDLE;
      end
      default: mseq_next = M_IDLE;
    endcase
  end

  always_ff @(posedge sys_clk_in) begin
    if (reset_in) begin
      entry_done_reg <= 1'b0;
      prog_mode_reg <= 1'b0;
      link_reg <= L_IDLE;
      ack_reg <= AK_WRITE;
      sess_reg <= S_CODE;
      mseq_reg <= M_IDLE;
      bit_cnt_reg <= 3'h0;
      shift_reg <= 8'h00;
      cmd_reg <= 8'h00;
      arg_reg <= 8'h00;
      tx_reg <= 8'h00;
      cnt_reg <= 6'h00;
      wlen_reg <= 6'h00;
      wbase_reg <= 16'h0000;
      ptr_reg <= smp_pkg::PTR_RESET;
      timer_reg <= 17'h0;
      prog_after_reg <= 1'b0;
      lock_reg <= 1'b0;
      bad_cmd_reg <= 1'b0;
      ecc_fix_reg <= 1'b0;
      sda_oe_reg <= 1'b0;
      scl_oe_reg <= 1'b0;
      buf_reg <= '{default: 8'h00};
      mem_cmd_reg <= '{smp_pkg::MEM_NONE, 16'h0000, 12'h000};
    end else begin
      entry_done_reg <= entry_done_next;
      prog_mode_reg <= prog_mode_next;
      link_reg <= link_next;
      ack_reg <= ack_next;
      sess_reg <= sess_next;
      mseq_reg <= mseq_next;
      bit_cnt_reg <= bit_cnt_next;
      shift_reg <= shift_next;
      cmd_reg <= cmd_next;
      arg_reg <= arg_next;
      tx_reg <= tx_next;
      cnt_reg <= cnt_next;
      wlen_reg <= wlen_next;
      wbase_reg <= wbase_next;
      ptr_reg <= ptr_next;
      timer_reg <= timer_next;
      prog_after_reg <= prog_after_next;
      lock_reg <= lock_next;
      bad_cmd_reg <= bad_cmd_next;
      ecc_fix_reg <= ecc_fix_next;
      sda_oe_reg <= sda_oe_next;
      scl_oe_reg <= scl_oe_next;
      buf_reg <= buf_next;
      mem_cmd_reg <= mem_cmd_next;
    end
  end

  // ==========================================================================
  // Outputs; open-drain lines only ever pull low
  assign prog_mode_out = prog_mode_reg;
  assign osc_en_out    = prog_mode_reg;
  assign mem_power_out = prog_mode_reg;
  assign scl_out       = 1'b0;
  assign sda_out       = 1'b0;
  assign scl_oe_out    = scl_oe_reg;
  assign sda_oe_out    = sda_oe_reg;
  assign mem_cmd_out   = mem_cmd_reg;

  // ==========================================================================
  // Checks
  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (reset_in);

  sequence s_cmd(logic [7:0] c);
    fire && sess_reg == S_CMD && shift_reg == c;
  endsequence
  sequence s_last_data(logic [7:0] c);
    fire && sess_reg == S_DATA && cnt_reg == 6'h1F && cmd_reg == c;
  endsequence

  property p_strap_once;
    entry_done_reg |=> $stable(prog_mode_reg);
  endproperty
  a_strap_once: assert property (p_strap_once) else $error("mode changed after entry");
  property p_ptr_init;
    $rose(prog_mode_reg) |-> ptr_reg == smp_pkg::PTR_RESET;
  endproperty
  a_ptr_init: assert property (p_ptr_init) else $error("pointer not at lock byte");
  sequence s_own_addr;
    link_reg == L_ADDR && scl_rise && bit_cnt_reg == 3'h7
      && shift_reg[6:0] == smp_pkg::SLAVE_ADDR && !sda_s2;
  endsequence
  property p_addr_ack;
    s_own_addr |-> ##[1:16] sda_oe_reg;
  endproperty
  a_addr_ack: assert property (p_addr_ack) else $error("address not acknowledged");
  property p_advance;
    s_cmd(smp_pkg::CMD_BLK_ADV) |=> ptr_reg[7:5] == 3'($past(ptr_reg[7:5]) + 3'h1);
  endproperty
  a_advance: assert property (p_advance) else $error("block pointer not advanced");
  property p_page_sel;
    fire && sess_reg == S_ARG1 && cmd_reg == smp_pkg::CMD_PAGE_SEL
      |=> ptr_reg[15:8] == $past(shift_reg);
  endproperty
  a_page_sel: assert property (p_page_sel) else $error("page pointer not loaded");
  property p_ecc;
    mem_cmd_reg.op == smp_pkg::MEM_PROG |-> mem_cmd_reg.wdata[11:8] == ecc_bits(mem_cmd_reg.wdata[7:0]);
  endproperty
  a_ecc: assert property (p_ecc) else $error("check bits wrong");
  property p_full_clear;
    s_cmd(smp_pkg::CMD_FULL_CLR) |=> mem_cmd_reg.op == smp_pkg::MEM_CLR_ALL && !lock_reg
      && scl_oe_reg;
  endproperty
  a_full_clear: assert property (p_full_clear) else $error("full clear wrong");
  property p_bad_cmd;
    s_cmd(8'h07) |=> bad_cmd_reg && $stable(ptr_reg) && mseq_reg == M_IDLE;
  endproperty
  a_bad_cmd: assert property (p_bad_cmd) else $error("bad command not flagged");
  property p_noclr_write;
    s_last_data(smp_pkg::CMD_BLK_NOCLR) |-> ##2
      (mem_cmd_reg.op == smp_pkg::MEM_PROG && scl_oe_reg)[*8];
  endproperty
  a_noclr_write: assert property (p_noclr_write) else $error("no-erase block write wrong");
  property p_erase_first;
    s_last_data(smp_pkg::CMD_BLK_PROG) |=> mem_cmd_reg.op == smp_pkg::MEM_CLR_BLOCK ##1
      (scl_oe_reg && mem_cmd_reg.op == smp_pkg::MEM_NONE)[*8];
  endproperty
  a_erase_first: assert property (p_erase_first) else $error("block not erased first");

endmodule
`default_nettype wire

// *** test/smp_master_model.sv ***
// Programmer model: bus master on open-drain clock and data.
// Assumes pulled-up wires resolved by the bench.
`timescale 1ns/10ps
`default_nettype none
module smp_master_model (
  input  wire logic clk_in,
  input  wire logic scl_in,
  input  wire logic sda_in,
  output var logic  scl_low_out,
  output var logic  sda_low_out
);
  int stalls = 0;
  initial scl_low_out = 1'b0;
  initial sda_low_out = 1'b0;
  task automatic half;
    repeat (4) @(negedge clk_in);
  endtask
  // Bounded, so a stuck clock cannot hang the run
  task automatic rise;
    int k;
    scl_low_out = 1'b0;
    k = 0;
    @(negedge clk_in);
    while (scl_in !== 1'b1 && k < 400) begin
      @(negedge clk_in);
      k++;
    end
    if (k >= 400) stalls++;
    repeat (3) @(negedge clk_in);
  endtask
  task automatic bit_io(input logic b, output logic s);
    sda_low_out = ~b;
    half;
    rise;
    s = sda_in;
    scl_low_out = 1'b1;
  endtask
  // Ninth bit released: device ack on write, master nack on read
  task automatic xfer(input logic [7:0] d, output logic [7:0] q, output logic ack);
    for (int i = 7; i >= 0; i--) bit_io(d[i], q[i]);
    bit_io(1'b1, ack);
  endtask
  task automatic start;
    sda_low_out = 1'b1;
    half;
    scl_low_out = 1'b1;
  endtask
  task automatic stop;
    sda_low_out = 1'b1;
    half;
    rise;
    sda_low_out = 1'b0;
    half;
  endtask
endmodule
`default_nettype wire

// *** test/serial_memory_program_mode_tb.sv ***
// Bench: strap entry, pointers, fetches, memory operations.
// Assumes the master model on the wires and a one-cycle memory here.
`timescale 1ns/10ps
`default_nettype none
module serial_memory_program_mode_tb;
  logic sys_clk_in = 1'b0;
  logic reset_in = 1'b1;
  logic strap = 1'b0;
  logic [11:0] rdata = 12'h000;
  logic scl_oe, sda_oe, m_scl, m_sda, prog, osc, pwr, ak;
  logic [7:0] q;
  smp_pkg::smp_mem_cmd_s mc;
  int err_total = 0;
  int comparisons = 0;
  int st, n[8];
  logic [15:0] a[8];
  logic [11:0] w[8];
  wire scl_w = ~(scl_oe | m_scl);
  wire sda_w = ~(sda_oe | m_sda);
  always #20 sys_clk_in = ~sys_clk_in;
  smp_prog_mode #(.PROG_CYCLES(20), .ERASE_CYCLES(10)) i_dut (
    .sys_clk_in(sys_clk_in), .reset_in(reset_in), .program_select_pin_in(strap),
    .scl_in(scl_w), .sda_in(sda_w), .mem_rdata_in(rdata), .prog_mode_out(prog),
    .osc_en_out(osc), .mem_power_out(pwr), .scl_out(), .scl_oe_out(scl_oe),
    .sda_out(), .sda_oe_out(sda_oe), .mem_cmd_out(mc));
  smp_master_model i_m (.clk_in(sys_clk_in), .scl_in(scl_w), .sda_in(sda_w),
    .scl_low_out(m_scl), .sda_low_out(m_sda));
  function automatic logic [11:0] cw(input logic [7:0] d);
    logic [31:0] col = 32'hCBA97653;
    cw = {4'h0, d};
    for (int i = 0; i < 8; i++) if (d[i]) cw[11:8] ^= col[4*i+:4];
  endfunction
  // Memory answers one cycle late; op log kept per kind
  always @(posedge sys_clk_in) begin
    rdata <= cw(mc.addr[7:0] ^ 8'h5A) ^ {11'h000, mc.addr == 16'h1222};
    st <= st + int'(scl_oe);
    if (mc.op != smp_pkg::MEM_NONE) begin
      n[mc.op] <= n[mc.op] + 1;
      a[mc.op] <= mc.addr;
      w[mc.op] <= mc.wdata;
    end
  end
  task automatic chk(input string s, input logic [15:0] v, input logic [15:0] e);
    comparisons++;
    if (v !== e) begin
      err_total++;
      $display("[FAIL] %s expected %h seen %h", s, e, v);
    end
  endtask
  task automatic clr;
    st = 0;
    foreach (n[i]) n[i] = 0;
  endtask
  task automatic wb(input logic [7:0] d);
    i_m.xfer(d, q, ak);
    chk("ack", 16'(ak), 16'h0000);
  endtask
  // Stop waits out any stretch, then the session resumes
  task automatic brk;
    i_m.stop;
    i_m.start;
    wb(8'hA0);
  endtask
  task automatic rd(input logic [7:0] e);
    i_m.stop;
    i_m.start;
    wb(8'hA1);
    i_m.xfer(8'hFF, q, ak);
    chk("read byte", 16'(q), 16'(e));
    brk;
  endtask
  task automatic t_strap;
    repeat (2) @(negedge sys_clk_in);
    reset_in = 1'b0;
    repeat (4) @(negedge sys_clk_in);
    chk("mode off", 16'({prog, osc, pwr}), 16'h0000);
    i_m.start;
    i_m.xfer(8'hA0, q, ak);
    chk("no ack", 16'(ak), 16'h0001);
    i_m.stop;
    strap = 1'b1;
    reset_in = 1'b1;
    repeat (3) @(negedge sys_clk_in);
    reset_in = 1'b0;
    repeat (4) @(negedge sys_clk_in);
    chk("mode on", 16'({prog, osc, pwr}), 16'h0007);
    $display("strap test done");
  endtask
  task automatic t_fetch;
    i_m.start;
    wb(8'hA0);
    wb(8'h00);
    wb(8'h0C);
    wb(8'h12);
    wb(8'h0D);
    rd(8'h3A);
    chk("ptr", a[smp_pkg::MEM_READ], 16'h1260);
    wb(8'h05);
    wb(8'h22);
    rd(8'h78);
    chk("fetch at", a[smp_pkg::MEM_READ], 16'h1222);
    wb(8'h0D);
    rd(8'h79);
    chk("post inc", a[smp_pkg::MEM_READ], 16'h1223);
    $display("fetch test done");
  endtask
  task automatic t_prog(input logic [7:0] c, input int clrs);
    clr;
    wb(c);
    for (int i = 0; i < 32; i++) wb(8'(i + 3));
    brk;
    chk("prog n", 16'(n[smp_pkg::MEM_PROG]), 16'd32);
    chk("clr n", 16'(n[smp_pkg::MEM_CLR_BLOCK]), 16'(clrs));
    chk("prog at", a[smp_pkg::MEM_PROG], 16'h131F);
    chk("word", 16'(w[smp_pkg::MEM_PROG]), 16'(cw(8'd34)));
    chk("stretch", 16'(st >= 20 + 10 * clrs), 16'h0001);
    $display("block program test done");
  endtask
  task automatic t_bytes;
    clr;
    wb(8'h02);
    wb(8'h45);
    wb(8'hA5);
    brk;
    chk("byte clr", a[smp_pkg::MEM_CLR_BYTE], 16'h1345);
    chk("byte prog", a[smp_pkg::MEM_PROG], 16'h1345);
    chk("byte word", 16'(w[smp_pkg::MEM_PROG]), 16'(cw(8'hA5)));
    wb(8'h04);
    wb(8'h07);
    brk;
    chk("erase at", a[smp_pkg::MEM_CLR_BYTE], 16'h1307);
    wb(8'h03);
    wb(8'hA7);
    brk;
    chk("blk erase", a[smp_pkg::MEM_CLR_BLOCK], 16'h13A0);
    wb(8'h0C);
    wb(8'h30);
    wb(8'h02);
    wb(8'h00);
    wb(8'hC3);
    wb(8'h02);
    wb(8'h60);
    wb(8'h01);
    wb(8'h13);
    rd(8'h05);
    chk("lock at", a[smp_pkg::MEM_PROG], 16'h3060);
    wb(8'h0D);
    rd(8'h00);
    clr;
    wb(8'h09);
    brk;
    chk("full", 16'(n[smp_pkg::MEM_CLR_ALL]), 16'h0001);
    chk("hold", 16'(st >= 10), 16'h0001);
    clr;
    wb(8'h07);
    brk;
    chk("no op", 16'(n[1] + n[2] + n[3] + n[4]), 16'h0000);
    wb(8'h13);
    rd(8'h02);
    wb(8'h13);
    rd(8'h00);
    i_m.stop;
    $display("byte and status test done");
  endtask
  task automatic report_and_stop;
    $display("Comparisons %0d mismatches %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  initial begin
    clr;
    t_strap;
    t_fetch;
    repeat (7) wb(8'h0F);
    t_prog(8'h0B, 0);
    t_prog(8'h01, 1);
    t_bytes;
    chk("stalls", 16'(i_m.stalls), 16'h0000);
    report_and_stop;
  end
endmodule
`default_nettype wire
